// File: core/drp_pkg.sv
// constants shared by the burst read port and its data fifo
package drp_pkg;
	// data word and array organisation: one location holds a two-word burst
	localparam int WORD_W = 18;
	localparam int BYTE_W = 9;
	localparam int BYTES_PER_WORD = 2;
	localparam int ADDR_W = 20;
	localparam int LINE_W = 2 * WORD_W;
	// fifo in the read data path
	localparam int FIFO_DEPTH = 4;
	// clock: each ref_clk_i edge is one rise of the positive or negative input clock
	localparam int CLK_PERIOD_PS = 5000;
	// read latency in ref_clk_i edges: 2.0 cycles with the loop on, 1.0 with it off
	localparam int LAT_DLL_ON = 4;
	localparam int LAT_DLL_OFF = 2;
	// pending history depth covers the second word of the slowest latency
	localparam int HIST_W = LAT_DLL_ON + 1;
	// write data arrives one positive clock cycle after the address
	localparam int WR_HIST_W = 3;
	// loop lock time in positive clock cycles of stable clock
	localparam int DLL_LOCK_CYCLES = 2048;
	localparam int LOCK_CNT_W = 12;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_MAX = 12'h800;
	// highest positive clock rate the controller may use with the loop off
	localparam int DLL_OFF_MAX_MHZ = 167;
	// values after reset
	localparam logic [WORD_W-1:0] DQ_RST = 18'h00000;
	localparam logic PHASE_RST = 1'b0;
endpackage : drp_pkg

// File: core/drp_fifo_if.sv
// handshake bundle between the read port and its data fifo
`timescale 1ns/10ps
interface drp_fifo_if #(
	parameter int WIDTH = 36
);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;

	modport fill (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface : drp_fifo_if

// File: core/drp_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module drp_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	drp_fifo_if.store fifo
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] store_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;
	wire push;
	wire pop;
	wire [PTR_W-1:0] next_wr_ptr;
	wire [PTR_W-1:0] next_rd_ptr;

	// handshakes and honest full/empty
	assign fifo.in_ready = (count != DEPTH_CNT);
	assign fifo.out_valid = (count != '0);
	assign fifo.out_data = store_mem[rd_ptr];
	assign push = fifo.in_valid & fifo.in_ready;
	assign pop = fifo.out_valid & fifo.out_ready;
	assign next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
	assign next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;

	// storage, no reset needed
	always_ff @(posedge ref_clk_i)
	begin
		if (push)
			store_mem[wr_ptr] <= fifo.in_data;
	end

	// pointers and fill count
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= next_wr_ptr;
			if (pop)
				rd_ptr <= next_rd_ptr;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule : drp_fifo

// File: core/drp_read_port.sv
// double-rate burst sram core: address/control capture, array, burst output
`timescale 1ns/10ps
module drp_read_port #(
	parameter int WORD_W = drp_pkg::WORD_W,
	parameter int ADDR_W = drp_pkg::ADDR_W,
	parameter int FIFO_DEPTH = drp_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic load_strobe_n_i,
	input wire logic rw_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [WORD_W-1:0] dq_i,
	input wire logic [drp_pkg::BYTES_PER_WORD-1:0] byte_write_sel_n_i,
	input wire logic dll_disable_n_i,
	output logic [WORD_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic out_valid_flag_o,
	output logic echo_timing_out_o,
	output logic dll_locked_o,
	output logic k_phase_o,
	output wire logic rd_ready_o
);
	localparam int LINE_W = 2 * WORD_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BW = drp_pkg::BYTE_W;

	// phase and request decode
	logic phase;
	wire k_edge;
	wire rd_req;
	wire wr_req;

	// read history: hist[n] is a read taken n edges ago
	logic [drp_pkg::HIST_W:1] hist;
	wire dll_on;
	wire launch0;
	wire launch1;
	wire valid_set;

	// write pipeline
	logic [drp_pkg::WR_HIST_W:1] wr_hist;
	logic [ADDR_W-1:0] wr_addr1;
	logic [ADDR_W-1:0] wr_addr2;
	logic [WORD_W-1:0] wr_lo;
	logic [drp_pkg::BYTES_PER_WORD-1:0] wr_lo_sel_n;
	wire capture_lo;
	wire commit;
	wire [LINE_W-1:0] old_line;
	wire [LINE_W-1:0] new_line;

	// array and lock counter
	logic [LINE_W-1:0] array_mem [DEPTH];
	logic [drp_pkg::LOCK_CNT_W-1:0] lock_cnt;

	drp_fifo_if #(.WIDTH(LINE_W)) rd_fifo ();

	// edges alternate: phase low means this edge is a positive clock rise
	assign k_edge = (phase == 1'b0);
	// read only when the fifo can take the line; strobe high is a no-operation
	assign rd_req = k_edge & ~load_strobe_n_i & rw_i & rd_fifo.in_ready;
	assign wr_req = k_edge & ~load_strobe_n_i & ~rw_i;
	assign rd_ready_o = rd_fifo.in_ready;

	// latency select: loop on gives 2.0 cycles, off gives 1.0 cycle
	assign dll_on = dll_disable_n_i;
	assign launch0 = dll_on ? hist[drp_pkg::LAT_DLL_ON] : hist[drp_pkg::LAT_DLL_OFF];
	assign launch1 = dll_on ? hist[drp_pkg::LAT_DLL_ON + 1]
		: hist[drp_pkg::LAT_DLL_OFF + 1];
	assign valid_set = dll_on
		? (hist[drp_pkg::LAT_DLL_ON - 1] | hist[drp_pkg::LAT_DLL_ON])
		: (hist[drp_pkg::LAT_DLL_OFF - 1] | hist[drp_pkg::LAT_DLL_OFF]);

	// the whole location goes into the fifo at the request edge
	assign rd_fifo.in_valid = rd_req;
	assign rd_fifo.in_data = array_mem[addr_i];
	assign rd_fifo.out_ready = launch1;

	// write: first word on the following positive rise, second on the negative rise
	assign capture_lo = wr_hist[2];
	assign commit = wr_hist[3];
	assign old_line = array_mem[wr_addr2];
	assign new_line = {
		byte_write_sel_n_i[1] ? old_line[LINE_W-1 -: BW] : dq_i[WORD_W-1 -: BW],
		byte_write_sel_n_i[0] ? old_line[WORD_W +: BW] : dq_i[BW-1:0],
		wr_lo_sel_n[1] ? old_line[WORD_W-1 -: BW] : wr_lo[WORD_W-1 -: BW],
		wr_lo_sel_n[0] ? old_line[BW-1:0] : wr_lo[BW-1:0]
	};

	// phase toggles every edge; first edge after reset is a positive rise
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			phase <= drp_pkg::PHASE_RST;
		else
			phase <= ~phase;
	end

	// echo clock follows the positive clock; phase output shows which half runs
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			echo_timing_out_o <= 1'b0;
			k_phase_o <= 1'b0;
		end
		else
		begin
			echo_timing_out_o <= k_edge;
			k_phase_o <= k_edge;
		end
	end

	// read history shifts every edge so pending bursts finish after deselect
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			hist <= '0;
		else
			hist <= {hist[drp_pkg::HIST_W-1:1], rd_req};
	end

	// output data registers: first word from loaded address, then the next
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			dq_o <= drp_pkg::DQ_RST;
		else if (launch0)
			dq_o <= rd_fifo.out_data[WORD_W-1:0];
		else if (launch1)
			dq_o <= rd_fifo.out_data[LINE_W-1:WORD_W];
	end

	// drive enable: set by a first word, dropped at the next idle positive rise
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			dq_oe_o <= 1'b0;
		else if (k_edge)
			dq_oe_o <= launch0;
	end

	// valid flag leads each word by one edge, half a clock cycle
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			out_valid_flag_o <= 1'b0;
		else
			out_valid_flag_o <= valid_set;
	end

	// write control pipeline: address moves on at the data positive rise
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_hist <= '0;
			wr_addr1 <= '0;
			wr_addr2 <= '0;
			wr_lo <= '0;
			wr_lo_sel_n <= '1;
		end
		else
		begin
			wr_hist <= {wr_hist[drp_pkg::WR_HIST_W-1:1], wr_req};
			if (wr_req)
				wr_addr1 <= addr_i;
			if (capture_lo)
			begin
				wr_addr2 <= wr_addr1;
				wr_lo <= dq_i;
				wr_lo_sel_n <= byte_write_sel_n_i;
			end
		end
	end

	// array write of the full two-word line at the negative rise
	always_ff @(posedge ref_clk_i)
	begin
		if (commit)
			array_mem[wr_addr2] <= new_line;
	end

	// loop lock: counts stable positive clock rises while enabled
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			lock_cnt <= '0;
		else if (~dll_disable_n_i)
			lock_cnt <= '0;
		else if (k_edge && lock_cnt != drp_pkg::LOCK_CNT_MAX)
			lock_cnt <= lock_cnt + 1'b1;
	end

	// lock indicator, a register
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			dll_locked_o <= 1'b0;
		else
			dll_locked_o <= dll_disable_n_i & (lock_cnt == drp_pkg::LOCK_CNT_MAX);
	end

	// read data fifo
	drp_fifo #(
		.WIDTH(LINE_W),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.fifo(rd_fifo)
	);
endmodule : drp_read_port

// File: verif/drp_read_port_asserts.sv
// timing checks on the read port outputs
`timescale 1ns/10ps
module drp_read_port_asserts (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic load_strobe_n_i,
	input wire logic rw_i,
	input wire logic dll_disable_n_i,
	input wire logic dq_oe_o,
	input wire logic out_valid_flag_o,
	input wire logic echo_timing_out_o,
	input wire logic dll_locked_o,
	input wire logic k_phase_o,
	input wire logic rd_ready_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// read taken at a K edge gives valid then a two-word burst
	property p_read_lat_on;
		!k_phase_o && !load_strobe_n_i && rw_i && rd_ready_o && dll_disable_n_i |->
		##4 out_valid_flag_o ##1 (out_valid_flag_o && dq_oe_o) ##1 dq_oe_o;
	endproperty
	a_read_lat_on: assert property (p_read_lat_on) else $error("read latency wrong");
	property p_read_lat_off;
		!k_phase_o && !load_strobe_n_i && rw_i && rd_ready_o && !dll_disable_n_i |->
		##2 out_valid_flag_o ##1 (out_valid_flag_o && dq_oe_o) ##1 dq_oe_o;
	endproperty
	a_read_lat_off: assert property (p_read_lat_off) else $error("loop off latency");
	property p_oe_rise;
		$rose(dq_oe_o) |-> k_phase_o && $past(out_valid_flag_o);
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive start misplaced");
	property p_oe_fall;
		$fell(dq_oe_o) |-> k_phase_o;
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("float not after K edge");
	property p_burst_whole;
		$rose(dq_oe_o) |=> dq_oe_o;
	endproperty
	a_burst_whole: assert property (p_burst_whole) else $error("burst cut short");
	property p_valid_pair;
		$rose(out_valid_flag_o) |=> out_valid_flag_o;
	endproperty
	a_valid_pair: assert property (p_valid_pair) else $error("valid too short");
	property p_phase_alt;
		!k_phase_o |=> k_phase_o && echo_timing_out_o;
	endproperty
	a_phase_alt: assert property (p_phase_alt) else $error("phase not alternating");
	property p_phase_back;
		k_phase_o |=> !k_phase_o && !echo_timing_out_o;
	endproperty
	a_phase_back: assert property (p_phase_back) else $error("phase stuck high");
	property p_lock_src;
		$rose(dll_locked_o) |-> dll_disable_n_i;
	endproperty
	a_lock_src: assert property (p_lock_src) else $error("lock with loop off");
endmodule : drp_read_port_asserts

// File: verif/drp_ctrl_model.sv
// controller model driving requests and write data
`timescale 1ns/10ps
module drp_ctrl_model #(
	parameter int ADDR_W = 4
) (
	input wire logic ref_clk_i,
	output logic load_strobe_n_o,
	output logic rw_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [17:0] dq_o,
	output logic [1:0] byte_write_sel_n_o
);
	// idle bus at time zero
	initial
	begin
		load_strobe_n_o = 1'b1;
		rw_o = 1'b0;
		addr_o = '0;
		dq_o = 18'h00000;
		byte_write_sel_n_o = 2'h3;
	end
	// one request at a K edge, or at the K# edge when kn is set
	task automatic req(input logic rd, input logic [ADDR_W-1:0] a, input bit kn);
		if (kn)
			@(negedge ref_clk_i);
		load_strobe_n_o = 1'b0;
		rw_o = rd;
		addr_o = a;
		@(negedge ref_clk_i);
		load_strobe_n_o = 1'b1;
		rw_o = ~rd;
		addr_o = ~a;
		if (!kn)
			@(negedge ref_clk_i);
	endtask : req
	// write data on the K and K# edges after the request
	task automatic wdata(input logic [17:0] w0, input logic [17:0] w1, input logic [1:0] sel);
		dq_o = w0;
		byte_write_sel_n_o = sel;
		@(negedge ref_clk_i);
		dq_o = w1;
		@(negedge ref_clk_i);
		dq_o = ~w1; // released bus shows no stale value
		byte_write_sel_n_o = 2'h3;
	endtask : wdata
endmodule : drp_ctrl_model

// File: verif/ddr_burst_sram_read_port_tb_top.sv
// self-checking bench for the burst read port
`timescale 1ns/10ps
module ddr_burst_sram_read_port_tb_top;
	localparam logic [17:0] W0 = 18'h1A5A5;
	localparam logic [17:0] W1 = 18'h2C3C3;
	localparam logic [17:0] W2 = 18'h0F0F0;
	localparam logic [17:0] W3 = 18'h30303;
	// location 4 after a write with only its upper byte enabled
	localparam logic [17:0] M2 = {9'h000, W2[8:0]};
	localparam logic [17:0] M3 = {9'h000, W3[8:0]};
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic dll_n = 1'b1;
	logic ld_n, rw, oe, valid, locked, rdy;
	logic echo, kph;
	logic [3:0] addr;
	logic [17:0] dq_in, dq_out;
	logic [1:0] sel_n;
	int failures = 0;
	int samples_checked = 0;
	// 200 MHz clock
	always #2.5 ref_clk_i = ~ref_clk_i;
	drp_ctrl_model #(.ADDR_W(4)) u_ctrl (.ref_clk_i(ref_clk_i), .load_strobe_n_o(ld_n),
		.rw_o(rw), .addr_o(addr), .dq_o(dq_in), .byte_write_sel_n_o(sel_n));
	drp_read_port #(.ADDR_W(4)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.load_strobe_n_i(ld_n), .rw_i(rw), .addr_i(addr), .dq_i(dq_in),
		.byte_write_sel_n_i(sel_n), .dll_disable_n_i(dll_n), .dq_o(dq_out), .dq_oe_o(oe),
		.out_valid_flag_o(valid), .echo_timing_out_o(echo), .dll_locked_o(locked),
		.k_phase_o(kph), .rd_ready_o(rdy));
	task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// follow outputs edge by edge from the K edge of the first request
	task automatic watch(input int lat, input int n, input logic [17:0] w[4]);
		bit on;
		for (int i = 0; i < lat + n + 2; i++)
		begin
			@(negedge ref_clk_i);
			on = (i >= lat) && (i < lat + n);
			chk("enable", 36'(oe), 36'(on));
			chk("valid", 36'(valid), 36'((i >= lat - 1) && (i < lat + n - 1)));
			chk("ready", 36'(rdy), 36'h1);
			chk("phase", 36'(kph), 36'(i % 2 == 0));
			chk("echo", 36'(echo), 36'(i % 2 == 0));
			if (on)
				chk("data", 36'(dq_out), 36'(w[i - lat]));
		end
	endtask : watch
	// write two locations, read both back to back
	task automatic s_write_read;
		u_ctrl.req(1'b0, 4'h3, 1'b0);
		u_ctrl.wdata(W0, W1, 2'h0);
		u_ctrl.req(1'b0, 4'h4, 1'b0);
		u_ctrl.wdata(W2, W3, 2'h0);
		fork
			begin
				u_ctrl.req(1'b1, 4'h3, 1'b0);
				u_ctrl.req(1'b1, 4'h4, 1'b0);
			end
			watch(4, 4, '{W0, W1, W2, W3});
		join
	endtask : s_write_read
	// one byte kept per location by its select, then a K# request and a no-op
	task automatic s_mask_nop;
		u_ctrl.req(1'b0, 4'h3, 1'b0);
		u_ctrl.wdata(18'h3FFFF, 18'h3FFFF, 2'h2);
		u_ctrl.req(1'b0, 4'h4, 1'b0);
		u_ctrl.wdata(18'h00000, 18'h00000, 2'h1);
		fork
			begin
				u_ctrl.req(1'b1, 4'h3, 1'b0);
				u_ctrl.req(1'b1, 4'h4, 1'b0);
			end
			watch(4, 4, '{{W0[17:9], 9'h1FF}, {W1[17:9], 9'h1FF}, M2, M3});
		join
		fork
			u_ctrl.req(1'b1, 4'h4, 1'b1);
			watch(4, 0, '{W0, W1, W2, W3});
		join
	endtask : s_mask_nop
	// lock time, then loop off with short latency
	task automatic s_lock_off;
		repeat (4000) @(negedge ref_clk_i);
		chk("lock early", 36'(locked), 36'h0);
		repeat (200) @(negedge ref_clk_i);
		chk("lock", 36'(locked), 36'h1);
		dll_n = 1'b0;
		fork
			u_ctrl.req(1'b1, 4'h4, 1'b0);
			watch(2, 2, '{M2, M3, W0, W1});
		join
		chk("lock off", 36'(locked), 36'h0);
	endtask : s_lock_off
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// main sequence
	initial
	begin
		repeat (6) @(negedge ref_clk_i);
		chk("reset enable", 36'(oe), 36'h0);
		chk("reset valid", 36'(valid), 36'h0);
		rst_i = 1'b0;
		s_write_read();
		s_mask_nop();
		s_lock_off();
		results();
	end
	// watchdog
	initial
	begin
		repeat (6000) @(posedge ref_clk_i);
		failures++;
		results();
	end
endmodule : ddr_burst_sram_read_port_tb_top
bind drp_read_port drp_read_port_asserts u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.load_strobe_n_i(load_strobe_n_i), .rw_i(rw_i), .dll_disable_n_i(dll_disable_n_i),
	.dq_oe_o(dq_oe_o), .out_valid_flag_o(out_valid_flag_o),
	.echo_timing_out_o(echo_timing_out_o), .dll_locked_o(dll_locked_o),
	.k_phase_o(k_phase_o), .rd_ready_o(rd_ready_o));
